// [common/sbmp_pkg.sv]
// Package for the synchronous burst memory port
package sbmp_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int LAT_W  = 2;
    localparam logic [1:0] LAT_RST      = 2'h0;
    localparam logic       CSX_RST      = 1'b0;
    localparam logic       REN_RST      = 1'b0;
    localparam logic       CLKSEL_RST   = 1'b0;
    localparam logic [1:0] CLK_DIV_TWO  = 2'h1;
    localparam logic [2:0] DESELECT_CYC = 3'h1;

    typedef struct packed {
        logic [1:0] read_latency_sel;
        logic [1:0] write_latency_sel;
        logic       chip_select_extend;
        logic       read_enable_mode;
        logic       sync_clock_select;
    } sbmp_cfg_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        logic [DATA_W-1:0] wdata;
        logic              last;
    } sbmp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_CMD   = 3'h1,
        ST_DRAIN = 3'h3,
        ST_DESEL = 3'h2
    } sbmp_state_t;
endpackage

// [src/sbmp_port.sv]
// Synchronous burst memory port, synchronous interface mode
`timescale 1ns/1ps
module sbmp_port #(
    parameter int ADDR_W = sbmp_pkg::ADDR_W,
    parameter int DATA_W = sbmp_pkg::DATA_W,
    parameter int BE_W   = sbmp_pkg::BE_W
) (
    input  wire logic                  mclk_i,
    input  wire logic                  arst_n_i,
    input  wire sbmp_pkg::sbmp_cfg_t   cfg_i,
    input  wire logic                  req_valid_i,
    input  wire sbmp_pkg::sbmp_req_t   req_i,
    output logic                       req_ready_o,
    output logic                       rd_valid_o,
    output logic [DATA_W-1:0]          rd_data_o,
    output logic                       busy_o,
    output logic                       ext_clock_out_one_o,
    output logic                       ext_clock_out_two_o,
    output logic                       space_chip_select_n_o,
    output logic [BE_W-1:0]            byte_enable_n_o,
    output logic [ADDR_W-1:0]          address_o,
    output logic [DATA_W-1:0]          data_o,
    output logic                       data_oe_o,
    input  wire logic [DATA_W-1:0]     data_i,
    output logic                       sync_strobe_n_o,
    output logic                       sync_output_enable_n_o,
    output logic                       sync_write_enable_n_o
);
    logic                   tick;
    sbmp_pkg::sbmp_state_t  st_q, st_d;
    logic                   cs_q, cs_d;
    logic                   strb_q, strb_d;
    logic                   oe_q, oe_d;
    logic                   we_q, we_d;
    logic                   doe_q, doe_d;
    logic [BE_W-1:0]        be_q, be_d;
    logic [ADDR_W-1:0]      addr_q, addr_d;
    logic [DATA_W-1:0]      dat_q, dat_d;
    logic [3:0]             rpipe_q, rpipe_d;
    logic [3:0]             wpipe_q, wpipe_d;
    logic [DATA_W-1:0]      wdly_q [4];
    logic [DATA_W-1:0]      rdat_q, rdat_d;
    logic                   rval_q, rval_d;
    logic                   cur_wr_q, cur_wr_d;
    logic                   take;

    sbmp_tick u_tick (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .sel_i     (cfg_i.sync_clock_select),
        .clk_one_o (ext_clock_out_one_o),
        .clk_two_o (ext_clock_out_two_o),
        .tick_o    (tick)
    );

    function automatic logic lat_hit(input logic [3:0] pipe, input logic [1:0] lat);
        lat_hit = pipe[lat];
    endfunction

    assign take        = tick && (st_q == sbmp_pkg::ST_IDLE || st_q == sbmp_pkg::ST_CMD) && req_valid_i;
    assign req_ready_o = take;

    always_comb begin
        st_d     = st_q;
        cs_d     = cs_q;
        strb_d   = strb_q;
        oe_d     = oe_q;
        we_d     = we_q;
        be_d     = be_q;
        addr_d   = addr_q;
        cur_wr_d = cur_wr_q;
        rpipe_d  = rpipe_q;
        wpipe_d  = wpipe_q;
        if (tick) begin
            rpipe_d = {rpipe_q[2:0], 1'b0};
            wpipe_d = {wpipe_q[2:0], 1'b0};
            strb_d  = 1'b0;
            we_d    = 1'b0;
            case (st_q)
                sbmp_pkg::ST_IDLE, sbmp_pkg::ST_CMD: begin
                    if (req_valid_i) begin
                        st_d     = req_i.last ? sbmp_pkg::ST_DRAIN : sbmp_pkg::ST_CMD;
                        cs_d     = 1'b1;
                        strb_d   = 1'b1;
                        we_d     = req_i.wr;
                        oe_d     = !req_i.wr;
                        cur_wr_d = req_i.wr;
                        be_d     = req_i.be;
                        addr_d   = req_i.addr;
                        rpipe_d[0] = !req_i.wr;
                        wpipe_d[0] = req_i.wr;
                    end else if (st_q == sbmp_pkg::ST_CMD) begin
                        st_d = sbmp_pkg::ST_DRAIN;
                    end
                end
                sbmp_pkg::ST_DRAIN: begin
                    // Chip select off after last command unless extended with output enable
                    if (!cfg_i.chip_select_extend) begin
                        cs_d = 1'b0;
                    end
                    if (rpipe_q == 4'h0 && wpipe_q == 4'h0) begin
                        oe_d = 1'b0;
                        cs_d = 1'b0;
                        // FIFO mode skips the deselect cycle
                        st_d = cfg_i.read_enable_mode ? sbmp_pkg::ST_IDLE : sbmp_pkg::ST_DESEL;
                    end
                end
                sbmp_pkg::ST_DESEL: begin
                    st_d = sbmp_pkg::ST_IDLE;
                end
                default: begin
                    st_d = sbmp_pkg::ST_IDLE;
                    cs_d = 1'b0;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Write data delayed by write latency; read sampled after read latency
    always_comb begin
        dat_d  = dat_q;
        doe_d  = doe_q;
        rdat_d = rdat_q;
        rval_d = 1'b0;
        if (tick) begin
            doe_d = lat_hit(wpipe_d, cfg_i.write_latency_sel);
            if (doe_d) begin
                dat_d = (cfg_i.write_latency_sel == 2'h0) ? req_i.wdata : wdly_q[cfg_i.write_latency_sel];
            end
            // Command aged by the read latency; zero latency samples on the next launch edge
            if (lat_hit(rpipe_q, cfg_i.read_latency_sel) && !doe_q) begin
                rval_d = 1'b1;
                rdat_d = data_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q     <= sbmp_pkg::ST_IDLE;
            cs_q     <= 1'b0;
            strb_q   <= 1'b0;
            oe_q     <= 1'b0;
            we_q     <= 1'b0;
            doe_q    <= 1'b0;
            be_q     <= '0;
            addr_q   <= '0;
            dat_q    <= '0;
            rdat_q   <= '0;
            rval_q   <= 1'b0;
            cur_wr_q <= 1'b0;
            rpipe_q  <= 4'h0;
            wpipe_q  <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                wdly_q[i] <= '0;
            end
        end else begin
            st_q     <= st_d;
            cs_q     <= cs_d;
            strb_q   <= strb_d;
            oe_q     <= oe_d;
            we_q     <= we_d;
            doe_q    <= doe_d;
            be_q     <= be_d;
            addr_q   <= addr_d;
            dat_q    <= dat_d;
            rdat_q   <= rdat_d;
            rval_q   <= rval_d;
            cur_wr_q <= cur_wr_d;
            rpipe_q  <= rpipe_d;
            wpipe_q  <= wpipe_d;
            if (tick) begin
                wdly_q[1] <= take ? req_i.wdata : wdly_q[1];
                wdly_q[2] <= wdly_q[1];
                wdly_q[3] <= wdly_q[2];
                wdly_q[0] <= '0;
            end
        end
    end

    assign space_chip_select_n_o  = !cs_q;
    assign sync_strobe_n_o        = !strb_q;
    assign sync_output_enable_n_o = !oe_q;
    assign sync_write_enable_n_o  = !we_q;
    assign byte_enable_n_o        = ~be_q;
    assign address_o              = addr_q;
    assign data_o                 = dat_q;
    assign data_oe_o              = doe_q;
    assign rd_valid_o             = rval_q;
    assign rd_data_o              = rdat_q;
    assign busy_o                 = (st_q != sbmp_pkg::ST_IDLE);

    AST_STRB_CS: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !sync_strobe_n_o |-> !space_chip_select_n_o) else $error("strobe without chip select");
    AST_CSX: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (cfg_i.chip_select_extend && !sync_output_enable_n_o) |-> !space_chip_select_n_o)
        else $error("chip select dropped while output enable low");
    AST_DESEL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (st_q == sbmp_pkg::ST_DESEL && !tick) |=> st_q == sbmp_pkg::ST_DESEL) else $error("deselect skipped");
    AST_NODESEL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ($stable(cfg_i.read_enable_mode) && cfg_i.read_enable_mode && $past(cfg_i.read_enable_mode))
        |-> st_q != sbmp_pkg::ST_DESEL || $past(st_q) == sbmp_pkg::ST_DESEL
        || !$past(cfg_i.read_enable_mode, 2)) else $error("deselect in fifo mode");
    AST_TICK: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cfg_i.sync_clock_select |-> tick) else $error("clock one must launch every cycle");
    AST_WE_RD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !sync_write_enable_n_o |-> sync_output_enable_n_o) else $error("write and read enables both active");
    AST_RLAT0: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (tick && cfg_i.read_latency_sel == 2'h0 && rpipe_q[0] && !doe_q) |=> rd_valid_o)
        else $error("zero latency read not sampled");
    AST_WLAT0: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (take && req_i.wr && cfg_i.write_latency_sel == 2'h0) |=> data_oe_o) else $error("write data late");
    AST_CS_OFF: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (tick && st_q == sbmp_pkg::ST_DRAIN && !cfg_i.chip_select_extend) |=> space_chip_select_n_o)
        else $error("chip select held after last command");
endmodule

// [src/sbmp_tick.sv]
// Launch-edge generator for the two external output clocks
`timescale 1ns/1ps
module sbmp_tick (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic sel_i,
    output logic      clk_one_o,
    output logic      clk_two_o,
    output logic      tick_o
);
    logic [1:0] div_q;
    logic [1:0] div_d;

    always_comb begin
        div_d = div_q + 2'h1;
        if (div_q == sbmp_pkg::CLK_DIV_TWO) begin
            div_d = 2'h0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // Both clocks rise on the launch edge when sel_i picks clock two, so memory gets a full period of setup
    assign clk_one_o = mclk_i;
    assign clk_two_o = ~div_q[0];
    // Rising edges of the chosen clock are the launch points
    assign tick_o    = sel_i ? (div_q == sbmp_pkg::CLK_DIV_TWO) : 1'b1;
endmodule

// [test/sbmp_mem_model.sv]
// Behavioural synchronous burst memory on the far side of the port
`timescale 1ns/1ps
module sbmp_mem_model (
    input  wire logic                        mclk_i,
    input  wire sbmp_pkg::sbmp_cfg_t         cfg_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        stb_n_i,
    input  wire logic                        we_n_i,
    input  wire logic [sbmp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [sbmp_pkg::DATA_W-1:0] wdata_i,
    output logic      [sbmp_pkg::DATA_W-1:0] rdata_o
);
    logic [31:0] mem [16];
    logic [4:0]  rp_q [4];
    logic [4:0]  wp_q [4];
    logic [31:0] last_q = 32'h0;
    logic [4:0]  rc;
    logic [4:0]  wc;
    logic [4:0]  rs;
    logic [4:0]  ws;
    always_comb begin
        rc = {!cs_n_i && !stb_n_i && we_n_i, addr_i[3:0]};
        wc = {!cs_n_i && !we_n_i, addr_i[3:0]};
        rs = (cfg_i.read_latency_sel == 2'h0) ? rc : rp_q[cfg_i.read_latency_sel - 2'h1];
        ws = (cfg_i.write_latency_sel == 2'h0) ? wc : wp_q[cfg_i.write_latency_sel - 2'h1];
        // Released bus never repeats its last value
        rdata_o = rs[4] ? mem[rs[3:0]] : ~last_q;
    end
    // Only 16 words: address bits above 3 are ignored
    always @(posedge mclk_i) begin
        rp_q <= '{rc, rp_q[0], rp_q[1], rp_q[2]};
        wp_q <= '{wc, wp_q[0], wp_q[1], wp_q[2]};
        last_q <= rdata_o;
        if (ws[4]) begin
            mem[ws[3:0]] <= wdata_i;
        end
    end
endmodule

// [test/sbmp_port_tb.sv]
// Self-checking bench for the synchronous burst memory port
`timescale 1ns/1ps
module sbmp_port_tb;
    logic                mclk_i;
    logic                arst_n_i;
    sbmp_pkg::sbmp_cfg_t cfg;
    sbmp_pkg::sbmp_req_t req;
    logic                req_valid;
    logic                ready;
    logic                rd_valid;
    logic [31:0]         rd_data;
    logic                busy;
    logic                two;
    logic                cs_n;
    logic [19:0]         addr;
    logic [31:0]         wdata;
    logic [31:0]         rdata;
    logic                stb_n;
    logic                oe_n;
    logic                we_n;
    logic [31:0]         rq [$];
    int                  stb_cnt;
    int                  we_cnt;
    int                  doe_cnt;
    int                  gap_cnt;
    int                  csoff_cnt;
    logic                stb_prev = 1'b1;
    logic                one;
    logic [3:0]          be_n;
    logic                doe;
    int                  fail_count = 0;
    int                  cmp_count = 0;
    sbmp_port i_sbmp_port (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_i(cfg), .req_valid_i(req_valid),
        .req_i(req), .req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .busy_o(busy),
        .ext_clock_out_one_o(one), .ext_clock_out_two_o(two), .space_chip_select_n_o(cs_n),
        .byte_enable_n_o(be_n), .address_o(addr), .data_o(wdata), .data_oe_o(doe), .data_i(rdata),
        .sync_strobe_n_o(stb_n), .sync_output_enable_n_o(oe_n), .sync_write_enable_n_o(we_n));
    sbmp_mem_model i_sbmp_mem_model (.mclk_i(mclk_i), .cfg_i(cfg), .cs_n_i(cs_n), .stb_n_i(stb_n),
        .we_n_i(we_n), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Monitor at the falling edge, where registered pins are settled
    always @(negedge mclk_i) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (stb_n === 1'b0) stb_cnt++;
        if (we_n === 1'b0) we_cnt++;
        if (doe === 1'b1) doe_cnt++;
        if (busy === 1'b1 && cs_n === 1'b1 && oe_n === 1'b1) gap_cnt++;
        if (cs_n === 1'b1 && oe_n === 1'b0) csoff_cnt++;
        if (cfg.chip_select_extend && oe_n === 1'b0) check({31'h0, cs_n}, 32'h0);
        if (stb_n === 1'b0) check({28'h0, be_n}, 32'h0);
        // First strobe of a burst must follow a rising edge of clock two
        if (cfg.sync_clock_select && stb_n === 1'b0 && stb_prev === 1'b1) check({31'h0, two}, 32'h1);
        stb_prev = stb_n;
    end
    // Called at a falling edge; request held until taken
    task automatic burst(input logic wr, input logic [31:0] base);
        int n;
        for (int i = 0; i < 4; i++) begin
            req = '{wr, 20'(i), 4'hF, base + 32'(i), i == 3};
            req_valid = 1'b1;
            n = 0;
            #10;
            while (ready !== 1'b1 && n < 100) begin
                @(negedge mclk_i);
                #10;
                n++;
            end
            if (n >= 100) fail_count++;
            @(negedge mclk_i);
        end
        req_valid = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        repeat (6) @(negedge mclk_i);
        check(32'(busy), 32'h0);
    endtask
    task automatic run(input int k, input logic [1:0] rl, input logic [1:0] wl, input logic mode);
        logic [31:0] base;
        base = 32'hA500_0000 + (32'(k) << 8);
        cfg = '{rl, wl, mode, mode, k == 8};
        stb_cnt = 0;
        we_cnt = 0;
        doe_cnt = 0;
        gap_cnt = 0;
        burst(1'b1, base);
        check(32'(we_cnt), (k == 8) ? 32'h8 : 32'h4);
        check(32'(doe_cnt), (k == 8) ? 32'h8 : 32'h4);
        check(32'(gap_cnt != 0), {31'h0, !mode});
        rq.delete();
        stb_cnt = 0;
        doe_cnt = 0;
        gap_cnt = 0;
        csoff_cnt = 0;
        burst(1'b0, base);
        check(32'(stb_cnt), (k == 8) ? 32'h8 : 32'h4);
        check(32'(rq.size()), 32'h4);
        for (int i = 0; i < 4; i++) check(rq[i], base + 32'(i));
        check(32'(doe_cnt), 32'h0);
        check(32'(gap_cnt != 0), {31'h0, !mode});
        check(32'(csoff_cnt != 0), {31'h0, !mode});
        if (!mode) check({31'h0, cs_n}, 32'h1);
        $display("test %0d done rl=%0d wl=%0d mode=%0d", k, rl, wl, mode);
    endtask
    initial begin
        arst_n_i = 1'b0;
        cfg = '0;
        req = '0;
        req_valid = 1'b0;
        repeat (20) @(negedge mclk_i);
        arst_n_i = 1'b1;
        @(negedge mclk_i);
        check({31'h0, cs_n}, 32'h1);
        for (int k = 0; k < 8; k++) run(k, 2'(k), 2'(3 - k), k[2]);
        run(8, 2'h0, 2'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            logic v;
            v = two;
            @(negedge mclk_i);
            check({31'h0, two}, {31'h0, ~v});
            check({31'h0, one}, 32'h0);
        end
        conclude();
    end
    initial begin
        #2000000;
        fail_count++;
        conclude();
    end
endmodule
